// ==== logic/serial_eeprom.v ====
/*
 * Serial EEPROM command interface: start detection, instruction decode,
 * read with sequential advance, self-timed erase/write with ready/busy
 * polling, and the program-enable latch. Array held in flip-flops.
 * Assumes chip_select, serial_clk, serial_in and word_width_select come
 * from pins outside the clk_sys domain; serial_clk is far slower.
 */
`timescale 1ns/1ps
`include "eeprom_cmd_defines.vh"
module serial_eeprom #(
	parameter ADDR_BITS_X8 = 9,                      // Byte address width.
	parameter WORD_CYCLES  = `MS_CYCLES(`WORD_CYCLE_MS),
	parameter ERASE_ALL_CYCLES = `MS_CYCLES(`ERASE_ALL_MS),
	parameter WRITE_ALL_CYCLES = `MS_CYCLES(`WRITE_ALL_MS)
) (
	input  wire clk_sys,           // System clock, 25 MHz.
	input  wire rst_n,             // Power-up reset, active low.
	input  wire chip_select,       // Select pin, active high.
	input  wire serial_clk,        // Serial clock pin.
	input  wire serial_in,         // Serial data input pin.
	input  wire word_width_select, // High: 16-bit words; low: bytes.
	output reg  serial_out,        // Serial data output value.
	output reg  serial_out_oe,     // High while serial_out is driven.
	output reg  busy               // Self-timed cycle running.
);
	localparam AW  = ADDR_BITS_X8;
	localparam NB  = 1 << AW;
	localparam [4:0]  AW5      = ADDR_BITS_X8;
	localparam [24:0] WORD_LEN = WORD_CYCLES;
	localparam [24:0] EALL_LEN = ERASE_ALL_CYCLES;
	localparam [24:0] WALL_LEN = WRITE_ALL_CYCLES;
	localparam S_IDLE = 3'd0;
	localparam S_OPC  = 3'd1;
	localparam S_ADDR = 3'd2;
	localparam S_DATA = 3'd3;
	localparam S_READ = 3'd4;
	localparam S_DONE = 3'd5;
	localparam P_NONE  = 2'd0;
	localparam P_ERASE = 2'd1;
	localparam P_WRITE = 2'd2;

	wire [3:0] pins_s;
	reg        cs_d_r, sck_d_r, width16_r;
	reg  [2:0] state_r;
	reg  [4:0] cnt_r;
	reg  [1:0] opc_r;
	reg  [AW-1:0] addr_r;
	reg  [15:0] data_r;
	reg  [15:0] shout_r;
	reg        enable_r;
	reg  [1:0] pend_r;
	reg        pend_all_r;
	reg  [24:0] timer_r;
	reg  [1:0] op_r;
	reg        op_all_r;
	reg  [AW-1:0] op_addr_r;
	reg  [15:0] op_data_r;
	reg  [7:0] mem_r [0:NB-1];
	reg  [3:0] csl_cnt_r;
	reg        status_arm_r;
	integer    i;

	pin_sync #(.WIDTH(4)) u_sync (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.d       ({word_width_select, chip_select, serial_clk,
			serial_in}),
		.q       (pins_s)
	);

	wire cs_s   = pins_s[2];
	wire sck_s  = pins_s[1];
	wire din_s  = pins_s[0];
	wire sck_rise = sck_s & ~sck_d_r & cs_s;
	wire cs_fall  = cs_d_r & ~cs_s;
	wire cs_rise  = cs_s & ~cs_d_r;
	wire x16      = width16_r;
	wire [4:0] abits = x16 ? AW5 - 5'd1 : AW5;
	wire [4:0] dbits = x16 ? 5'd16 : 5'd8;

	// Byte index of the low byte of a word at addr in the current width.
	function [AW-1:0] byte_idx;
		input [AW-1:0] a;
		input          w16;
		begin
			byte_idx = w16 ? {a[AW-2:0], 1'b0} : a;
		end
	endfunction

	wire [AW-1:0] rd_idx = byte_idx(addr_r, x16);
	wire [15:0] rd_word = x16 ? {mem_r[rd_idx + 1'b1], mem_r[rd_idx]}
		: {mem_r[rd_idx], 8'h00};
	wire [AW-1:0] addr_inc = x16 ?
		{1'b0, addr_r[AW-2:0] + 1'b1} : addr_r + 1'b1;

	// Width strap is caught after reset release, every clock.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cs_d_r  <= 1'b0;
			sck_d_r <= 1'b0;
			width16_r <= 1'b0;
		end else begin
			cs_d_r  <= cs_s;
			sck_d_r <= sck_s;
			width16_r <= pins_s[3];
		end
	end

	// Instruction shifter. Select low holds it idle with the count cleared; the enable latch keeps its value.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_r    <= S_IDLE;
			cnt_r      <= 5'd0;
			opc_r      <= 2'b00;
			addr_r     <= {AW{1'b0}};
			data_r     <= 16'h0000;
			shout_r    <= 16'h0000;
			enable_r   <= 1'b0;
			pend_r     <= P_NONE;
			pend_all_r <= 1'b0;
		end else if (!cs_s) begin
			state_r <= S_IDLE;
			cnt_r   <= 5'd0;
			if (!cs_fall)
				pend_r <= P_NONE;
		end else if (sck_rise) begin
			case (state_r)
			S_IDLE: begin
				if (din_s && !busy) begin
					state_r <= S_OPC;
					cnt_r   <= 5'd0;
				end
			end
			S_OPC: begin
				opc_r <= {opc_r[0], din_s};
				cnt_r <= cnt_r + 5'd1;
				if (cnt_r == 5'd1) begin
					state_r <= S_ADDR;
					cnt_r   <= 5'd0;
				end
			end
			S_ADDR: begin
				addr_r <= {addr_r[AW-2:0], din_s};
				cnt_r  <= cnt_r + 5'd1;
				if (cnt_r == abits - 5'd1) begin
					cnt_r <= 5'd0;
					state_r <= S_DONE;
					case (opc_r)
					`OP_READ: begin
						state_r <= S_READ;
						shout_r <= 16'h0000;
					end
					`OP_WRITE:
						state_r <= S_DATA;
					`OP_ERASE: begin
						pend_r <= enable_r ?
							P_ERASE : P_NONE;
						pend_all_r <= 1'b0;
					end
					default: begin
						// Leading address bits pick the command.
						case (x16 ? addr_r[AW-3:AW-4]
							: addr_r[AW-2:AW-3])
						`SUB_ENABLE:
							enable_r <= 1'b1;
						`SUB_DISABLE:
							enable_r <= 1'b0;
						`SUB_ERASE_ALL: begin
							pend_r <= enable_r ?
								P_ERASE : P_NONE;
							pend_all_r <= 1'b1;
						end
						default:
							state_r <= S_DATA;
						endcase
					end
					endcase
				end
			end
			S_DATA: begin
				data_r <= {data_r[14:0], din_s};
				cnt_r  <= cnt_r + 5'd1;
				if (cnt_r == dbits - 5'd1) begin
					state_r    <= S_DONE;
					pend_r     <= enable_r ?
						P_WRITE : P_NONE;
					pend_all_r <= (opc_r == `OP_SPECIAL);
				end
			end
			S_READ: begin
				// Dummy zero first, then word bits; wraps on.
				cnt_r <= cnt_r + 5'd1;
				if (cnt_r == 5'd0)
					shout_r <= rd_word;
				else
					shout_r <= {shout_r[14:0], 1'b0};
				if (cnt_r == dbits) begin
					addr_r <= addr_inc;
					cnt_r  <= 5'd1;
					shout_r <= x16 ?
						{mem_r[byte_idx(addr_inc, 1'b1) + 1'b1],
						mem_r[byte_idx(addr_inc, 1'b1)]}
						: {mem_r[addr_inc], 8'h00};
				end
			end
			S_DONE: state_r <= S_DONE;
			default: state_r <= S_IDLE;
			endcase
		end else if (state_r == S_ADDR || state_r == S_OPC
			|| state_r == S_DATA) begin
			pend_r <= P_NONE;
		end
	end

	// Self-timed programming engine, started by select falling.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			busy      <= 1'b0;
			timer_r   <= 25'd0;
			op_r      <= P_NONE;
			op_all_r  <= 1'b0;
			op_addr_r <= {AW{1'b0}};
			op_data_r <= 16'h0000;
			for (i = 0; i < NB; i = i + 1)
				mem_r[i] <= 8'hff;
		end else if (!busy) begin
			if (cs_fall && pend_r != P_NONE && state_r == S_DONE) begin
				busy      <= 1'b1;
				op_r      <= pend_r;
				op_all_r  <= pend_all_r;
				op_addr_r <= byte_idx(addr_r, x16);
				op_data_r <= x16 ? data_r : {data_r[7:0], 8'h00};
				timer_r   <= pend_all_r ? (pend_r == P_WRITE ?
					WALL_LEN : EALL_LEN)
					: WORD_LEN;
			end
		end else if (timer_r != 25'd1) begin
			timer_r <= timer_r - 25'd1;
		end else begin
			busy <= 1'b0;
			for (i = 0; i < NB; i = i + 1) begin
				if (op_all_r || i == op_addr_r ||
					(x16 && i == op_addr_r + 1))
					mem_r[i] <= (op_r == P_ERASE) ? 8'hff :
						(x16 && i[0]) ? op_data_r[15:8]
						: (x16 ? op_data_r[7:0]
						: op_data_r[15:8]);
			end
		end
	end

	// Select must stay low long enough before status is shown.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			csl_cnt_r    <= 4'd0;
			status_arm_r <= 1'b0;
		end else if (cs_s) begin
			csl_cnt_r <= 4'd0;
			if (cs_fall)
				status_arm_r <= 1'b0;
			else if (cs_rise && csl_cnt_r >= `CSL_MIN_CYCLES)
				status_arm_r <= busy;
		end else if (csl_cnt_r != 4'hf) begin
			csl_cnt_r <= csl_cnt_r + 4'd1;
		end
	end

	// Output driver.
	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (!cs_s) begin
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end else if (state_r == S_READ) begin
			serial_out_oe <= 1'b1;
			serial_out    <= (cnt_r == 5'd0) ? 1'b0 : shout_r[15];
		end else if (status_arm_r) begin
			serial_out_oe <= 1'b1;
			serial_out    <= ~busy;
		end else begin
			serial_out    <= 1'b0;
			serial_out_oe <= 1'b0;
		end
	end
endmodule // serial_eeprom

// ==== logic/eeprom_cmd_defines.vh ====
/*
 * Constants of the serial EEPROM command interface: opcodes, special
 * command codes, self-timed cycle lengths and the minimum select-low time.
 * Assumes a system clock of 25 MHz; included by serial_eeprom.
 */
`ifndef EEPROM_CMD_DEFINES_VH
`define EEPROM_CMD_DEFINES_VH

`define OP_SPECIAL      2'b00
`define OP_WRITE        2'b01
`define OP_READ         2'b10
`define OP_ERASE        2'b11

`define SUB_DISABLE     2'b00
`define SUB_WRITE_ALL   2'b01
`define SUB_ERASE_ALL   2'b10
`define SUB_ENABLE      2'b11

`define CLK_SYS_MHZ     25
`define WORD_CYCLE_MS   4
`define ERASE_ALL_MS    8
`define WRITE_ALL_MS    16
`define MS_CYCLES(ms)   ((ms) * 1000 * `CLK_SYS_MHZ)

`define CSL_MIN_NS      250
`define CLK_SYS_NS      40
`define CSL_MIN_CYCLES  ((`CSL_MIN_NS + `CLK_SYS_NS - 1) / `CLK_SYS_NS)

`endif

// ==== logic/pin_sync.v ====
/*
 * Two-flip-flop synchroniser for a group of pin inputs.
 * Assumes the inputs are asynchronous to clk_sys.
 */
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 3
) (
	input  wire             clk_sys, // System clock.
	input  wire             rst_n,   // Asynchronous reset, active low.
	input  wire [WIDTH-1:0] d,       // Asynchronous inputs.
	output reg  [WIDTH-1:0] q        // Synchronised outputs.
);
	reg [WIDTH-1:0] meta_r;

	always @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= {WIDTH{1'b0}};
			q      <= {WIDTH{1'b0}};
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule // pin_sync

// ==== verif/eeprom_cmd_sva.sv ====
/* Port checker of serial_eeprom.
   Bound by the testbench; serial clock far below clk_sys. */
`timescale 1ns/1ps
module eeprom_cmd_sva #(
	parameter WORD_CYCLES = 50, // Word cycle.
	parameter WRITE_ALL_CYCLES = 200 // Longest cycle.
) (
	input wire clk_sys,       // Clock.
	input wire rst_n,         // Reset.
	input wire chip_select,   // Select.
	input wire serial_clk,    // Serial clock.
	input wire serial_out,    // Data out.
	input wire serial_out_oe, // Out enable.
	input wire busy           // Cycle runs.
);
	reg [31:0] len_r; // Busy cycles so far.
	always @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
			len_r <= 32'h0;
		else
			len_r <= busy ? len_r + 32'h1 : 32'h0;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	a_oe_deselect: assert property (
		!chip_select [*6] |-> !serial_out_oe)
		else $error("Output driven while deselected.");
	a_oe_select: assert property (
		$rose(serial_out_oe) |-> chip_select)
		else $error("Output enabled unselected.");
	a_busy_start: assert property (
		$rose(busy) |-> !chip_select && !$past(chip_select))
		else $error("Cycle began while selected.");
	a_busy_hold: assert property (
		$rose(busy) |=> busy [*8])
		else $error("Cycle cut short.");
	a_busy_len: assert property (
		$fell(busy) |-> len_r >= WORD_CYCLES - 2
		&& len_r <= WRITE_ALL_CYCLES + 8)
		else $error("Cycle length wrong.");
	a_status_low: assert property (
		serial_out_oe && busy && $past(busy) |-> !serial_out)
		else $error("Status high while busy.");
	a_status_ready: assert property (
		serial_out_oe && $fell(busy)
		|-> ##[0:4] serial_out || !serial_out_oe)
		else $error("Ready not shown.");
	a_read_stable: assert property (
		(serial_out_oe && !busy && !serial_clk) [*4]
		|=> $stable(serial_out) || !serial_out_oe)
		else $error("Output moved without a clock.");
	c_cycle: cover property ($rose(busy));
	c_status: cover property (serial_out_oe && busy);
	c_read: cover property (serial_out_oe && !busy && !serial_out);
endmodule // eeprom_cmd_sva

// ==== verif/eeprom_host.sv ====
/* Host model driving the three serial pins.
   Output line has a pull-up; one bit per 320 ns plus slow. */
`timescale 1ns/1ps
module eeprom_host (
	output reg  chip_select,  // Select.
	output reg  serial_clk,   // Serial clock.
	output reg  serial_in,    // Data in.
	input  wire serial_out,   // Data out.
	input  wire serial_out_oe // Out enable.
);
	wire        dout = serial_out_oe ? serial_out : 1'b1;
	reg  [31:0] got = 32'h0;
	integer     slow = 0;
	initial begin
		chip_select = 1'b0;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end
	// Sends n bits MSB first, sampling the output late in each bit.
	task shift(input [31:0] b, input integer n);
		integer i;
		begin
			chip_select = 1'b1;
			for (i = n - 1; i >= 0; i = i - 1) begin
				serial_in = b[i];
				#(83 + slow) serial_clk = 1'b1;
				#157 serial_clk = 1'b0;
				#80 got = {got[30:0], dout};
			end
			serial_in = ~serial_in;
		end
	endtask
	task drop;
		begin
			chip_select = 1'b0;
			#280;
		end
	endtask
	task poll;
		begin
			chip_select = 1'b1;
			#200;
		end
	endtask
endmodule // eeprom_host

// ==== verif/testbench.sv ====
/* Bench of serial_eeprom with the host model on its pins.
   Short self-timed cycles; the checker is bound here. */
`timescale 1ns/1ps
module testbench;
	reg     clk_sys = 1'b0;
	reg     rst_n = 1'b0;
	reg     word_width_select = 1'b0;
	wire    chip_select, serial_clk, serial_in;
	wire    serial_out, serial_out_oe, busy;
	integer num_errors = 0;
	integer n_tests = 0;
	integer k;
	always #20 clk_sys = ~clk_sys;
	serial_eeprom #(.WORD_CYCLES(50), .ERASE_ALL_CYCLES(100),
		.WRITE_ALL_CYCLES(200)) serial_eeprom_inst (.clk_sys(clk_sys),
		.rst_n(rst_n), .chip_select(chip_select),
		.serial_clk(serial_clk), .serial_in(serial_in),
		.word_width_select(word_width_select), .busy(busy),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));
	eeprom_host eeprom_host_inst (.chip_select(chip_select),
		.serial_clk(serial_clk), .serial_in(serial_in),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe));
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task give_verdict;
		begin
			$display("Errors %0d, checks %0d", num_errors, n_tests);
			if (num_errors == 0 && n_tests > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task off;
		begin
			eeprom_host_inst.drop;
			chk(serial_out_oe, 0);
		end
	endtask
	// Polls status through a whole cycle: busy first, then ready.
	task wait_ready;
		begin
			eeprom_host_inst.poll;
			chk(eeprom_host_inst.dout, 0);
			for (k = 0; k < 1000 && busy !== 1'b0; k = k + 1)
				@(posedge clk_sys);
			if (k == 1000) begin
				num_errors = num_errors + 1;
				$display("MISMATCH %0t busy never cleared", $time);
				give_verdict;
			end
			#200 chk(eeprom_host_inst.dout, 1);
			off;
		end
	endtask
	task op(input [31:0] b, input integer n, input e);
		begin
			eeprom_host_inst.shift(b, n);
			off;
			#80 chk(busy, e);
			if (e)
				wait_ready;
		end
	endtask
	task rd(input [8:0] a, input integer na, input integer nd,
		input [31:0] exp);
		begin
			eeprom_host_inst.shift(((32'h6 << na) | a) << nd,
				3 + na + nd);
			chk(eeprom_host_inst.got & ((32'h1 << (nd + 1)) - 1),
				exp);
			off;
		end
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		repeat (4) @(posedge clk_sys);
		op({3'b101, 9'h010, 8'ha5}, 20, 0);
		rd(9'h010, 9, 8, 32'hff);
		eeprom_host_inst.shift(32'h0, 6);
		chk(serial_out_oe, 0);
		op(32'h980, 12, 0);
		op({3'b101, 9'h010, 8'ha5}, 20, 1);
		op({3'b101, 9'h011, 8'h3c}, 20, 1);
		rd(9'h010, 9, 16, 32'ha53c);
		@(posedge clk_sys) #1 word_width_select = 1'b1;
		rd(9'h008, 8, 16, 32'h3ca5);
		@(posedge clk_sys) #1 word_width_select = 1'b0;
		op({3'b101, 9'h010, 5'h00}, 17, 0);
		op({3'b111, 9'h011}, 12, 1);
		rd(9'h010, 9, 16, 32'ha5ff);
		op(32'h900, 12, 1);
		rd(9'h010, 9, 8, 32'hff);
		op({5'b10001, 7'h00, 8'h5a}, 20, 1);
		eeprom_host_inst.slow = 400;
		rd(9'h1fe, 9, 16, 32'h5a5a);
		op(32'h800, 12, 0);
		op({3'b101, 9'h010, 8'h00}, 20, 0);
		rd(9'h010, 9, 8, 32'h5a);
		give_verdict;
	end
endmodule // testbench

bind serial_eeprom eeprom_cmd_sva #(.WORD_CYCLES(WORD_CYCLES),
	.WRITE_ALL_CYCLES(WRITE_ALL_CYCLES)) eeprom_cmd_sva_inst (
	.clk_sys(clk_sys),
	.rst_n(rst_n), .chip_select(chip_select), .busy(busy),
	.serial_clk(serial_clk), .serial_out(serial_out),
	.serial_out_oe(serial_out_oe));
